// File: design/lsp_logic_tile.sv
`default_nettype none

module lsp_logic_tile
    import lsp_pkg::*;
#(
    parameter int SLICES = LSP_SLICES,
    parameter int FGS = LSP_FGS,
    parameter int FG_IN = LSP_FG_INPUTS,
    parameter int DEPTH = LSP_FG_DEPTH
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cfgLoad,
    input wire logic [SLICES-1:0] sliceClk,
    input wire logic [SLICES-1:0] clkEnable,
    input wire logic [SLICES-1:0] clkEnableUsed,
    input wire logic [SLICES-1:0] forceControlIn,
    input wire logic [SLICES-1:0] oppositeForceIn,
    input wire logic [SLICES-1:0] directDataUpper,
    input wire logic [SLICES-1:0] f5Select,
    input wire logic [SLICES-1:0] wideSelect,
    input wire logic [LSP_COLUMNS-1:0] carryIn,
    input wire logic shiftChainIn,
    input wire logic [FGS*FG_IN-1:0] fgAddr,
    input wire logic [FGS-1:0] fgWrData,
    input wire logic [SLICES-1:0] fgWrEnable,
    input wire logic [FGS*LSP_FG_MODE_W-1:0] fgMode,
    input wire logic [FGS*DEPTH-1:0] fgTable,
    input wire logic [SLICES-1:0] latchMode,
    input wire logic [FGS-1:0] dataDirect,
    input wire logic [SLICES-1:0] clkInvert,
    input wire logic [SLICES-1:0] ceInvert,
    input wire logic [SLICES-1:0] forceInvert,
    input wire logic [SLICES-1:0] oppInvert,
    input wire logic [SLICES-1:0] forceUsed,
    input wire logic [FGS-1:0] forceOneAttr,
    input wire logic [FGS-1:0] startupIndep,
    input wire logic [FGS-1:0] startupOneAttr,
    input wire logic [SLICES-1:0] syncForce,
    output logic [FGS-1:0] fgOut,
    output logic [FGS-1:0] storeOut,
    output logic [SLICES-1:0] f5Out,
    output logic [SLICES-1:0] wideOut,
    output logic [LSP_COLUMNS-1:0] carryOut,
    output logic shiftChainOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rstMeta;
    logic rstSyncN;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice clock sampling
    logic [SLICES-1:0] clkMeta;
    logic [SLICES-1:0] clkSync;
    logic [SLICES-1:0] clkPrev;
    logic [SLICES-1:0] clkLevel;
    logic [SLICES-1:0] clkEdge;

    // Slice clocks arrive from routing: two flops, then edge history
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            clkMeta <= '0;
            clkSync <= '0;
            clkPrev <= '0;
        end else begin
            clkMeta <= sliceClk;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared slice controls
    logic [SLICES-1:0] ceEff;
    logic [SLICES-1:0] forceAct;
    logic [SLICES-1:0] oppAct;
    logic [SLICES-1:0] lutRouteUpper;
    logic [SLICES-1:0] lutRouteLower;
    logic [SLICES-1:0] next_f5Out;
    logic [SLICES-1:0] next_wideOut;
    logic [SLICES-1:0] carryOutSlice;
    logic [SLICES-1:0] carryInSlice;

    generate
        for (genvar s = 0; s < SLICES; s++) begin : gSliceCtl
            // Clock level and one-cycle active edge after polarity
            assign clkLevel[s] = lsp_apply_pol(clkSync[s], clkInvert[s]);
            assign clkEdge[s] = clkLevel[s] && !lsp_apply_pol(clkPrev[s], clkInvert[s]);

            // Enable polarity, unused enable reads as asserted
            assign ceEff[s] = !clkEnableUsed[s]
                || lsp_apply_pol(clkEnable[s], ceInvert[s]);

            // Force inputs only act when the force path is used
            assign forceAct[s] = forceUsed[s]
                && lsp_apply_pol(forceControlIn[s], forceInvert[s]);
            assign oppAct[s] = forceUsed[s]
                && lsp_apply_pol(oppositeForceIn[s], oppInvert[s]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Function generators and the shared shift chain
    logic [FGS-1:0] lutComb;
    logic [FGS:0] shiftLink;

    assign shiftLink[0] = shiftChainIn;

    generate
        for (genvar i = 0; i < FGS; i++) begin : gFg
            // Generator i lives in slice i/2: even is upper, odd is lower
            lsp_func_gen #(
                .DEPTH(DEPTH),
                .AW(FG_IN)
            ) uFg (
                .clk(ref_clk),
                .rstN(rstSyncN),
                .initPulse(cfgLoad),
                .cfgTable(fgTable[i*DEPTH +: DEPTH]),
                .mode(lsp_fg_mode_t'(fgMode[i*LSP_FG_MODE_W +: LSP_FG_MODE_W])),
                .addr(fgAddr[i*FG_IN +: FG_IN]),
                .wrData(fgWrData[i]),
                .wrEn(fgWrEnable[i/LSP_FG_PER_SLICE]),
                .clkEdge(clkEdge[i/LSP_FG_PER_SLICE]),
                .ceEff(ceEff[i/LSP_FG_PER_SLICE]),
                .shiftIn(shiftLink[i]),
                .lutOut(lutComb[i]),
                .shiftOut(shiftLink[i+1])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Routed generator outputs, combiners and carry
    generate
        for (genvar s = 0; s < SLICES; s++) begin : gSliceData
            // Generator outputs route to storage data
            assign lutRouteUpper[s] = lutComb[2*s];
            assign lutRouteLower[s] = lutComb[2*s+1];

            // Five-input combiner: select input picks the lower or upper table
            assign next_f5Out[s] = f5Select[s] ? lutComb[2*s+1] : lutComb[2*s];

            // Wide combiner merges this slice's and the partner's combiner
            assign next_wideOut[s] = wideSelect[s] ? next_f5Out[s^1] : next_f5Out[s];

            // Carry: upper table output propagates, else direct input generates
            assign carryOutSlice[s] = lutComb[2*s] ? carryInSlice[s] : directDataUpper[s];
        end

        for (genvar c = 0; c < LSP_COLUMNS; c++) begin : gColumn
            // Two independent chains, one per column of two slices
            assign carryInSlice[2*c] = carryIn[c];
            assign carryInSlice[2*c+1] = carryOutSlice[2*c];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Storage elements
    logic [FGS-1:0] storeData;
    logic [FGS-1:0] startupVal;
    logic [FGS-1:0] resetAct;
    logic [FGS-1:0] setAct;

    generate
        for (genvar e = 0; e < FGS; e++) begin : gStore
            localparam int S = e / LSP_FG_PER_SLICE;

            // Data source: routed generator output or direct slice input
            if (e % LSP_FG_PER_SLICE == 0) begin : gUpper
                assign storeData[e] = dataDirect[e] ? directDataUpper[S]
                    : lutRouteUpper[S];
            end else begin : gLower
                assign storeData[e] = dataDirect[e] ? oppositeForceIn[S]
                    : lutRouteLower[S];
            end

            // Force attribute chooses which input resets and which sets
            assign resetAct[e] = forceOneAttr[e] ? oppAct[S] : forceAct[S];
            assign setAct[e] = forceOneAttr[e] ? forceAct[S] : oppAct[S];

            // Startup follows force attribute unless chosen on its own
            assign startupVal[e] = startupIndep[e] ? startupOneAttr[e]
                : forceOneAttr[e];

            // Clock, enable and force are the slice's shared copies
            lsp_storage uStore (
                .clk(ref_clk),
                .rstN(rstSyncN),
                .initPulse(cfgLoad),
                .startupVal(startupVal[e]),
                .latchMode(latchMode[S]),
                .syncMode(syncForce[S]),
                .clkEdge(clkEdge[S]),
                .clkLevel(clkLevel[S]),
                .ceEff(ceEff[S]),
                .dIn(storeData[e]),
                .resetAct(resetAct[e]),
                .setAct(setAct[e]),
                .q(storeOut[e])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Registered slice outputs
    // Generator and combiner outputs, one cycle after address
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            fgOut <= '0;
            f5Out <= '0;
            wideOut <= '0;
        end else begin
            fgOut <= lutComb;
            f5Out <= next_f5Out;
            wideOut <= next_wideOut;
        end
    end

    // Carry column ends and end of shift chain
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            carryOut <= '0;
            shiftChainOut <= 1'b0;
        end else begin
            carryOut <= {carryOutSlice[3], carryOutSlice[1]};
            shiftChainOut <= shiftLink[FGS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking tileCk @(posedge ref_clk);
    endclocking
    default disable iff (!rstSyncN);

    generate
        for (genvar e = 0; e < FGS; e++) begin : gStartupChk
            AST_STARTUP: assert property (
                cfgLoad |=> storeOut[e] == $past(startupIndep[e] ? startupOneAttr[e]
                    : forceOneAttr[e]))
                else $error("startup value wrong after init");
        end
        for (genvar s = 0; s < SLICES; s++) begin : gF5Chk
            AST_F5_MERGE: assert property (
                ##1 f5Out[s] == ($past(f5Select[s]) ? fgOut[2*s+1] : fgOut[2*s]))
                else $error("five-input combiner mismatch");
        end
    endgenerate

    COV_INIT: cover property (cfgLoad ##1 !cfgLoad);
    COV_EDGE: cover property (clkEdge[0] && ceEff[0]);

endmodule : lsp_logic_tile

`default_nettype wire

// File: design/lsp_pkg.sv
`default_nettype none

package lsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Tile geometry
    localparam int LSP_SLICES = 4;
    localparam int LSP_COLUMNS = 2;
    localparam int LSP_FG_PER_SLICE = 2;
    localparam int LSP_FGS = LSP_SLICES * LSP_FG_PER_SLICE;
    localparam int LSP_FG_INPUTS = 4;
    localparam int LSP_FG_DEPTH = 16;
    localparam int LSP_FG_MODE_W = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic LSP_RST_VAL = 1'b0;
    localparam logic [LSP_FG_DEPTH-1:0] LSP_CELLS_RST = 16'h0000;

    // Function generator modes
    typedef enum logic [LSP_FG_MODE_W-1:0] {
        LSP_FG_LUT,
        LSP_FG_RAM,
        LSP_FG_SHIFT
    } lsp_fg_mode_t;

    // Applies a configured polarity to a control input
    function automatic logic lsp_apply_pol(input logic sig, input logic inv);
        return sig ^ inv;
    endfunction : lsp_apply_pol

endpackage : lsp_pkg

`default_nettype wire

// File: design/lsp_func_gen.sv
`default_nettype none

module lsp_func_gen
    import lsp_pkg::*;
#(
    parameter int DEPTH = LSP_FG_DEPTH,
    parameter int AW = LSP_FG_INPUTS
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic initPulse,
    input wire logic [DEPTH-1:0] cfgTable,
    input wire lsp_fg_mode_t mode,
    input wire logic [AW-1:0] addr,
    input wire logic wrData,
    input wire logic wrEn,
    input wire logic clkEdge,
    input wire logic ceEff,
    input wire logic shiftIn,
    output logic lutOut,
    output logic shiftOut
);

    logic [DEPTH-1:0] cells;

    ////////////////////////////////////////////////////////////////////////////
    // Cell contents: loaded at init, written as memory or shifted
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cells <= LSP_CELLS_RST;
        end else if (initPulse) begin
            cells <= cfgTable;
        end else if (clkEdge && ceEff) begin
            unique case (mode)
                LSP_FG_RAM: begin
                    if (wrEn) begin
                        cells[addr] <= wrData;
                    end
                end
                LSP_FG_SHIFT: begin
                    cells <= {cells[DEPTH-2:0], shiftIn};
                end
                LSP_FG_LUT: begin
                end
                default: begin
                end
            endcase
        end
    end

    // Same read path for every mode, tap selected by address
    assign lutOut = cells[addr];
    assign shiftOut = cells[DEPTH-1];

endmodule : lsp_func_gen

`default_nettype wire

// File: design/lsp_storage.sv
`default_nettype none

module lsp_storage
    import lsp_pkg::*;
(
    input wire logic clk,
    input wire logic rstN,
    input wire logic initPulse,
    input wire logic startupVal,
    input wire logic latchMode,
    input wire logic syncMode,
    input wire logic clkEdge,
    input wire logic clkLevel,
    input wire logic ceEff,
    input wire logic dIn,
    input wire logic resetAct,
    input wire logic setAct,
    output logic q
);

    logic active;

    // Capture moment: edge as flip-flop, level as latch
    assign active = latchMode ? clkLevel : clkEdge;

    ////////////////////////////////////////////////////////////////////////////
    // Storage state with init, force and data paths
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= LSP_RST_VAL;
        end else if (initPulse) begin
            q <= startupVal;
        end else if (!syncMode && (resetAct || setAct)) begin
            q <= !resetAct;
        end else if (syncMode && active && (resetAct || setAct)) begin
            q <= !resetAct;
        end else if (ceEff && active) begin
            q <= dIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking lspCk @(posedge clk);
    endclocking
    default disable iff (!rstN);

    AST_RESET_WINS: assert property (
        (!initPulse && !syncMode && resetAct && setAct) |=> !q)
        else $error("reset did not win over set");
    AST_ASYNC_SET: assert property (
        (!initPulse && !syncMode && setAct && !resetAct) |=> q)
        else $error("asynchronous set not immediate");
    AST_SYNC_WAIT: assert property (
        (!initPulse && syncMode && !active) |=> $stable(q))
        else $error("synchronous force acted without clock");
    AST_FF_CAPTURE: assert property (
        (!initPulse && !latchMode && clkEdge && ceEff && !resetAct && !setAct)
        |=> q == $past(dIn))
        else $error("flip-flop missed data at edge");
    AST_LATCH_FOLLOW: assert property (
        (!initPulse && latchMode && clkLevel && ceEff && !resetAct && !setAct) [*2]
        |=> q == $past(dIn))
        else $error("latch not transparent");
    AST_CE_HOLD: assert property (
        (!initPulse && !ceEff && !resetAct && !setAct) |=> $stable(q))
        else $error("storage changed with enable off");

    COV_LATCH: cover property (latchMode && clkLevel && ceEff ##1 latchMode && clkLevel);
    COV_ASYNC_RESET: cover property (!syncMode && resetAct && setAct);
    COV_SYNC_SET: cover property (syncMode && clkEdge && setAct && !resetAct);

endmodule : lsp_storage

`default_nettype wire

// File: bench/lsp_fabric_model.sv
`default_nettype none

module lsp_fabric_model (
    input wire logic ref_clk,
    input wire logic [3:0] idleLevel,
    input wire logic pulse,
    input wire logic [7:0] halfCycles,
    output logic [3:0] sliceClk
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] count = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse length counter, clock stands still at idle level between pulses
    always @(posedge ref_clk) begin
        if (pulse) begin
            count <= halfCycles;
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end

    // One pulse per slice, shared by both storage elements
    assign sliceClk = (count != 8'h00) ? ~idleLevel : idleLevel;

endmodule : lsp_fabric_model

`default_nettype wire

// File: bench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [1:0] which; logic [7:0] val;} lsp_exp_t;
    lsp_exp_t expQ[$];
    lsp_exp_t cur;
    logic [7:0] seen;
    logic [7:0] lastStore;
    string names [4] = '{"storeOut", "fgOut", "f5Out", "wideOut"};
    int fail_count = 0;
    int compares = 0;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfgLoad = 1'b0;
    logic pulse = 1'b0;
    logic [3:0] idleLevel = 4'h0;
    logic [3:0] sliceClk, clkEnable = 4'hf, clkEnableUsed = 4'hf, latchMode = 4'h0;
    logic [3:0] forceControlIn = 4'h0, oppositeForceIn = 4'h0, directDataUpper = 4'h0;
    logic [3:0] f5Select = 4'h0, wideSelect = 4'h0, clkInvert = 4'h0, ceInvert = 4'h0;
    logic [3:0] forceInvert = 4'h0, oppInvert = 4'h0, forceUsed = 4'h0, syncForce = 4'h0;
    logic [7:0] dataDirect = 8'h00, forceOneAttr = 8'h00, startupIndep = 8'h00;
    logic [7:0] startupOneAttr = 8'h00, fgOut, storeOut;
    logic [3:0] f5Out, wideOut;
    logic [15:0] fgMode = 16'h0000;
    logic [7:0] fgWrData = 8'h00;
    logic [3:0] fgWrEnable = 4'h0;
    logic [31:0] fgAddr = 32'h0000_0000;
    logic [127:0] fgTable = 128'h0;
    logic [3:0] ceTab [4] = '{4'h0, 4'hf, 4'h0, 4'h0};
    logic [3:0] invTab [4] = '{4'h0, 4'hf, 4'hf, 4'h0};
    logic [3:0] usedTab [4] = '{4'hf, 4'hf, 4'hf, 4'h0};
    logic capTab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    lsp_logic_tile DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .cfgLoad(cfgLoad), .sliceClk(sliceClk),
        .clkEnable(clkEnable), .clkEnableUsed(clkEnableUsed),
        .forceControlIn(forceControlIn), .oppositeForceIn(oppositeForceIn),
        .directDataUpper(directDataUpper), .f5Select(f5Select), .wideSelect(wideSelect),
        .carryIn(2'h0), .shiftChainIn(1'b0), .fgAddr(fgAddr), .fgWrData(fgWrData),
        .fgWrEnable(fgWrEnable), .fgMode(fgMode), .fgTable(fgTable), .latchMode(latchMode),
        .dataDirect(dataDirect), .clkInvert(clkInvert), .ceInvert(ceInvert),
        .forceInvert(forceInvert), .oppInvert(oppInvert), .forceUsed(forceUsed),
        .forceOneAttr(forceOneAttr), .startupIndep(startupIndep),
        .startupOneAttr(startupOneAttr), .syncForce(syncForce), .fgOut(fgOut),
        .storeOut(storeOut), .f5Out(f5Out), .wideOut(wideOut), .carryOut(), .shiftChainOut()
    );

    lsp_fabric_model partner (
        .ref_clk(ref_clk), .idleLevel(idleLevel), .pulse(pulse), .halfCycles(8'h03),
        .sliceClk(sliceClk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    always #5 ref_clk = ~ref_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic note(input logic [1:0] which, input logic [7:0] val);
        expQ.push_back('{which, val});
    endtask : note

    task automatic clk_pulse();
        @(posedge ref_clk);
        pulse <= 1'b1;
        @(posedge ref_clk);
        pulse <= 1'b0;
    endtask : clk_pulse

    // Table lookup per generator
    function automatic logic [7:0] lut_exp();
        logic [7:0] v;
        for (int e = 0; e < 8; e++) begin
            v[e] = fgTable[e*16 + fgAddr[e*4 +: 4]];
        end
        return v;
    endfunction : lut_exp

    function automatic logic [3:0] f5_exp(input logic [7:0] g);
        logic [3:0] v;
        for (int s = 0; s < 4; s++) begin
            v[s] = f5Select[s] ? g[2*s+1] : g[2*s];
        end
        return v;
    endfunction : f5_exp

    // Wide combiner: select picks the partner slice's combiner
    function automatic logic [3:0] wide_exp(input logic [3:0] f);
        logic [3:0] v;
        for (int s = 0; s < 4; s++) begin
            v[s] = wideSelect[s] ? f[s^1] : f[s];
        end
        return v;
    endfunction : wide_exp

    // Direct data: upper from directDataUpper, lower from oppositeForceIn
    function automatic logic [7:0] dir_exp();
        logic [7:0] v;
        for (int s = 0; s < 4; s++) begin
            v[2*s] = directDataUpper[s];
            v[2*s+1] = oppositeForceIn[s];
        end
        return v;
    endfunction : dir_exp

    task automatic report_and_stop();
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Watcher: compares every pending note against the settled outputs
    always @(negedge ref_clk) begin
        while (expQ.size() > 0) begin
            cur = expQ.pop_front();
            seen = (cur.which == 2'd0) ? storeOut : (cur.which == 2'd1) ? fgOut
                : (cur.which == 2'd2) ? {4'h0, f5Out} : {4'h0, wideOut};
            compares++;
            if (seen !== cur.val) begin
                fail_count++;
                $display("wrong value %s expected %h seen %h", names[cur.which], cur.val, seen);
            end
        end
    end

    // Watchdog against a hang
    initial begin
        tick(20000);
        fail_count++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h491f));
        tick(6);
        arst_n <= 1'b1;
        tick(3);
        // Startup values under random attributes
        for (int r = 0; r < 3; r++) begin
            forceOneAttr <= 8'($urandom());
            startupIndep <= 8'($urandom());
            startupOneAttr <= 8'($urandom());
            fgTable <= {$urandom(), $urandom(), $urandom(), $urandom()};
            cfgLoad <= 1'b1;
            tick(1);
            cfgLoad <= 1'b0;
            tick(6);
            note(2'd0, (startupIndep & startupOneAttr) | (~startupIndep & forceOneAttr));
        end
        // Table lookups and five-input combiner
        for (int a = 0; a < 6; a++) begin
            fgAddr <= $urandom();
            f5Select <= 4'($urandom());
            wideSelect <= 4'($urandom());
            tick(6);
            note(2'd1, lut_exp());
            note(2'd2, {4'h0, f5_exp(lut_exp())});
            note(2'd3, {4'h0, wide_exp(f5_exp(lut_exp()))});
        end
        // Flip-flop capture of direct data
        dataDirect <= 8'hff;
        directDataUpper <= 4'($urandom());
        oppositeForceIn <= 4'($urandom());
        clk_pulse();
        tick(6);
        lastStore = dir_exp();
        note(2'd0, lastStore);
        // Clock enable polarity and unconnected enable
        for (int i = 0; i < 4; i++) begin
            clkEnable <= ceTab[i];
            ceInvert <= invTab[i];
            clkEnableUsed <= usedTab[i];
            directDataUpper <= ~directDataUpper;
            oppositeForceIn <= ~oppositeForceIn;
            lastStore = capTab[i] ? ~lastStore : lastStore;
            clk_pulse();
            tick(6);
            note(2'd0, lastStore);
        end
        // Generator output into storage
        dataDirect <= 8'h00;
        clkEnableUsed <= 4'hf;
        clkEnable <= 4'hf;
        tick(6);
        clk_pulse();
        tick(6);
        note(2'd0, lut_exp());
        // Asynchronous force, opposite force, both together, inverted force
        forceUsed <= 4'hf;
        oppositeForceIn <= 4'h0;
        forceControlIn <= 4'hf;
        tick(6);
        note(2'd0, forceOneAttr);
        forceControlIn <= 4'h0;
        oppositeForceIn <= 4'hf;
        tick(6);
        note(2'd0, ~forceOneAttr);
        forceControlIn <= 4'hf;
        tick(6);
        note(2'd0, 8'h00);
        forceInvert <= 4'hf;
        forceControlIn <= 4'h0;
        oppositeForceIn <= 4'h0;
        tick(6);
        note(2'd0, forceOneAttr);
        // Synchronous opposite force waits for the slice clock
        syncForce <= 4'hf;
        forceInvert <= 4'h0;
        oppositeForceIn <= 4'hf;
        tick(6);
        note(2'd0, forceOneAttr);
        clk_pulse();
        tick(6);
        note(2'd0, ~forceOneAttr);
        oppositeForceIn <= 4'h0;
        forceUsed <= 4'h0;
        // Latch transparent while clock active, holding otherwise
        latchMode <= 4'hf;
        dataDirect <= 8'hff;
        idleLevel <= 4'hf;
        for (int k = 0; k < 2; k++) begin
            directDataUpper <= 4'($urandom());
            oppositeForceIn <= 4'($urandom());
            tick(6);
            lastStore = dir_exp();
            note(2'd0, lastStore);
        end
        idleLevel <= 4'h0;
        tick(6);
        directDataUpper <= ~directDataUpper;
        oppositeForceIn <= ~oppositeForceIn;
        tick(6);
        note(2'd0, lastStore);
        clkInvert <= 4'hf;
        tick(6);
        note(2'd0, ~lastStore);
        // Memory write, then one shift step moves the word up a cell
        fgMode <= 16'h5555;
        fgAddr <= 32'h7777_7777;
        fgWrData <= 8'($urandom());
        fgWrEnable <= 4'hf;
        clk_pulse();
        tick(10);
        note(2'd1, fgWrData);
        fgMode <= 16'haaaa;
        fgWrEnable <= 4'h0;
        clk_pulse();
        tick(10);
        fgAddr <= 32'h8888_8888;
        tick(2);
        note(2'd1, fgWrData);
        tick(3);
        report_and_stop();
    end

endmodule : tb

`default_nettype wire
